// ### timer_core.sv
// Purpose: 16-bit timer with one capture/compare channel
// Assumes: plain register port, read data one cycle after strobe
// Notes: the channel input is synchronous to clock_in
// How it works
// - output mode: enable bit gates pin drive
// - input mode: enable bit gates capture
// - polarity bits pick rising, falling or both
// - counter ticks at clock over divider plus one
// - divider write applies only on update
// - reload register sets the wrap value
// - zero reload value stops the counter
// - capture latches counter into match register
// - match register read-only in input mode
// - no preload: compare write applies at once
// - preload: compare write applies on update
// - active compare against counter drives output
// - direction field writable only while disabled
// - main output enable gates the pin
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module timer_core
    import timer_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    input wire logic clock_in, // system clock, 125 MHz
    input wire logic rst_in, // synchronous reset, high
    input wire logic [ADDR_W-1:0] addr_in, // register index
    input wire logic [DATA_W-1:0] wdata_in, // write data
    input wire logic write_in, // write strobe
    input wire logic read_in, // read strobe
    output logic [DATA_W-1:0] rdata_out, // read data, cycle after strobe
    input wire logic channel_input_signal_in, // capture input
    output logic channel_output_signal_out, // compare output pin level
    output logic channel_output_enable_out, // pin driver enable
    output logic update_out, // one-cycle update event pulse
    output logic capture_out // one-cycle capture pulse
);
    // elaboration check: registers and divider share one fixed word width
    if (WIDTH != DATA_W) begin : g_width_check
        $error("timer_core width must match register width");
    end

    typedef struct packed {
        logic [15:0] count_value;
        logic [15:0] clock_divider;
        logic [15:0] divider_active;
        logic [15:0] reload_limit;
        logic [15:0] match_capture_value;
        logic [15:0] match_active;
        logic [1:0] channel_direction_select;
        logic compare_preload_enable;
        logic channel_enable;
        logic channel_polarity;
        logic channel_polarity_extra;
        logic main_output_enable;
        logic update_flag;
        logic capture_flag;
        logic [15:0] rdata;
        logic out_level;
        logic out_enable;
        logic update_pulse;
        logic capture_pulse;
    } state_t;
    state_t cur;
    state_t next_cur;

    logic tick;
    logic cap_edge;
    logic running;
    logic is_input;
    logic is_output;
    logic wrap;
    logic compare_hit;

    // decode of the register index for a given strobe
    function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] want);
        hit = strobe && (a == want);
    endfunction

    assign is_input = (cur.channel_direction_select == DIR_INPUT);
    assign is_output = (cur.channel_direction_select == DIR_OUTPUT);
    assign running = (cur.reload_limit != RESET_ZERO);
    assign wrap = tick && (cur.count_value >= cur.reload_limit);

    // counter clock enable from the divider
    tick_divider #(
        .WIDTH(WIDTH)
    ) u_div (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .run_in(running),
        .restart_in(hit(write_in, addr_in, ADDR_COUNT)),
        .divide_in(cur.divider_active),
        .tick_out(tick)
    );

    // input edge selection
    edge_picker u_edge (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .sample_in(channel_input_signal_in),
        .select_in({cur.channel_polarity_extra, cur.channel_polarity}),
        .edge_out(cap_edge)
    );

    // compare hit while counter is below the active compare value
    assign compare_hit = (cur.count_value < cur.match_active);

    // next state: counter, shadows, registers and outputs
    always_comb begin
        next_cur = cur;
        next_cur.update_pulse = 1'b0;
        next_cur.capture_pulse = 1'b0;
        next_cur.rdata = '0;

        // counting and update event
        if (running && tick) begin
            if (wrap) begin
                next_cur.count_value = '0;
                next_cur.update_pulse = 1'b1;
                next_cur.update_flag = 1'b1;
                next_cur.divider_active = cur.clock_divider;
                if (is_output && cur.compare_preload_enable) begin
                    next_cur.match_active = cur.match_capture_value;
                end
            end else begin
                next_cur.count_value = cur.count_value + 16'h0001;
            end
        end

        // capture in input mode, gated by the enable bit
        if (is_input && cur.channel_enable && cap_edge) begin
            next_cur.match_capture_value = cur.count_value;
            next_cur.capture_pulse = 1'b1;
            next_cur.capture_flag = 1'b1;
        end

        // register writes; hardware sets above win over status clears
        if (write_in) begin
            case (addr_in)
                ADDR_COUNT: next_cur.count_value = wdata_in;
                ADDR_DIVIDER: next_cur.clock_divider = wdata_in;
                ADDR_RELOAD: next_cur.reload_limit = wdata_in;
                ADDR_MATCH: begin
                    // ignored while the channel is an input
                    if (!is_input) begin
                        next_cur.match_capture_value = wdata_in;
                        if (!cur.compare_preload_enable) begin
                            next_cur.match_active = wdata_in;
                        end
                    end
                end
                ADDR_MODE: begin
                    next_cur.compare_preload_enable = wdata_in[MODE_PRELOAD_BIT];
                    // direction only changes while the channel is off
                    if (!cur.channel_enable) begin
                        next_cur.channel_direction_select = wdata_in[MODE_DIR_LSB +: 2];
                    end
                end
                ADDR_ENABLE: begin
                    next_cur.channel_enable = wdata_in[EN_ENABLE_BIT];
                    next_cur.channel_polarity = wdata_in[EN_POL_BIT];
                    next_cur.channel_polarity_extra = wdata_in[EN_POL_EXTRA_BIT];
                end
                ADDR_MAIN: next_cur.main_output_enable = wdata_in[MAIN_OE_BIT];
                ADDR_STATUS: begin
                    // write one to clear; a same-cycle event keeps the flag
                    if (wdata_in[ST_UPDATE_BIT] && !next_cur.update_pulse) begin
                        next_cur.update_flag = 1'b0;
                    end
                    if (wdata_in[ST_CAPTURE_BIT] && !next_cur.capture_pulse) begin
                        next_cur.capture_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // read data stands in the cycle after the strobe only
        if (read_in) begin
            case (addr_in)
                ADDR_COUNT: next_cur.rdata = cur.count_value;
                ADDR_DIVIDER: next_cur.rdata = cur.clock_divider;
                ADDR_RELOAD: next_cur.rdata = cur.reload_limit;
                ADDR_MATCH: next_cur.rdata = cur.match_capture_value;
                ADDR_MODE: begin
                    next_cur.rdata[MODE_DIR_LSB +: 2] = cur.channel_direction_select;
                    next_cur.rdata[MODE_PRELOAD_BIT] = cur.compare_preload_enable;
                end
                ADDR_ENABLE: begin
                    next_cur.rdata[EN_ENABLE_BIT] = cur.channel_enable;
                    next_cur.rdata[EN_POL_BIT] = cur.channel_polarity;
                    next_cur.rdata[EN_POL_EXTRA_BIT] = cur.channel_polarity_extra;
                end
                ADDR_MAIN: next_cur.rdata[MAIN_OE_BIT] = cur.main_output_enable;
                ADDR_STATUS: begin
                    next_cur.rdata[ST_UPDATE_BIT] = cur.update_flag;
                    next_cur.rdata[ST_CAPTURE_BIT] = cur.capture_flag;
                end
                default: next_cur.rdata = '0; // unmapped reads as zero
            endcase
        end

        // pin: compare result, polarity, then both enables
        next_cur.out_level = compare_hit ^ cur.channel_polarity;
        next_cur.out_enable = is_output && cur.channel_enable
            && cur.main_output_enable;
        if (!next_cur.out_enable) begin
            next_cur.out_level = cur.channel_polarity; // idle: inactive level
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cur <= '0;
            cur.reload_limit <= RESET_RELOAD;
        end else begin
            cur <= next_cur;
        end
    end

    // every output comes from a state flip-flop
    assign rdata_out = cur.rdata;
    assign channel_output_signal_out = cur.out_level;
    assign channel_output_enable_out = cur.out_enable;
    assign update_out = cur.update_pulse;
    assign capture_out = cur.capture_pulse;
endmodule

// ### timer_pkg.sv
// Purpose: shared constants for the single channel timer core
// Assumes: 16-bit register port, word indices as addresses
// Notes: offsets are register indices on the plain port
package timer_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    // register indices
    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_DIVIDER = 4'h1;
    localparam logic [3:0] ADDR_RELOAD = 4'h2;
    localparam logic [3:0] ADDR_MATCH = 4'h3;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_ENABLE = 4'h5;
    localparam logic [3:0] ADDR_MAIN = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    // mode register fields
    localparam int MODE_DIR_LSB = 0;
    localparam int MODE_PRELOAD_BIT = 3;
    // enable register fields
    localparam int EN_ENABLE_BIT = 0;
    localparam int EN_POL_BIT = 1;
    localparam int EN_POL_EXTRA_BIT = 3;
    // main output register field
    localparam int MAIN_OE_BIT = 15;
    // status register fields
    localparam int ST_UPDATE_BIT = 0;
    localparam int ST_CAPTURE_BIT = 1;
    // direction codes
    localparam logic [1:0] DIR_OUTPUT = 2'h0;
    localparam logic [1:0] DIR_INPUT = 2'h1;
    // reset values
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam logic [15:0] RESET_RELOAD = 16'h0000;
    // edge select codes {polarity_extra, polarity}
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ### edge_picker.sv
// Purpose: detect the selected edge of the channel input signal
// Assumes: input already synchronous to clock_in
// Notes: reserved select code yields no edges
`timescale 1ns/1ns
module edge_picker
    import timer_pkg::*;
(
    input wire logic clock_in, // system clock
    input wire logic rst_in, // synchronous reset, high
    input wire logic sample_in, // channel input signal
    input wire logic [1:0] select_in, // {polarity_extra, polarity}
    output logic edge_out // one-cycle edge pulse
);
    typedef struct packed {
        logic last;
        logic edge_seen;
    } state_t;
    state_t cur;
    state_t next_cur;

    // edge decode from current and last sample
    always_comb begin
        next_cur = cur;
        next_cur.last = sample_in;
        case (select_in)
            EDGE_RISE: next_cur.edge_seen = sample_in & ~cur.last;
            EDGE_FALL: next_cur.edge_seen = ~sample_in & cur.last;
            EDGE_BOTH: next_cur.edge_seen = sample_in ^ cur.last;
            default: next_cur.edge_seen = 1'b0; // reserved code
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign edge_out = cur.edge_seen;
endmodule

// ### tick_divider.sv
// Purpose: divide the divider input clock into counter ticks
// Assumes: divider value loaded only by the parent on update
// Notes: tick is a one-cycle enable pulse, not a clock
`timescale 1ns/1ns
module tick_divider
    import timer_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    input wire logic clock_in, // system clock
    input wire logic rst_in, // synchronous reset, high
    input wire logic run_in, // counter allowed to run
    input wire logic restart_in, // clear the divider phase
    input wire logic [WIDTH-1:0] divide_in, // active divider value
    output logic tick_out // one-cycle counter clock enable
);
    // elaboration check: the phase counter is built for 1 to 32 bits only
    if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
        $error("tick_divider width unsupported");
    end

    typedef struct packed {
        logic [WIDTH-1:0] phase;
        logic tick;
    } state_t;
    state_t cur;
    state_t next_cur;

    // tick every divide_in+1 cycles
    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (restart_in || !run_in) begin
            next_cur.phase = '0;
        end else if (cur.phase >= divide_in) begin
            next_cur.phase = '0;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.phase = cur.phase + 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick_out = cur.tick;
endmodule

// ### timer_core_properties.sv
// Purpose: port-level checks for the timer core
// Assumes: one clock domain, bound to timer_core
// Notes: copies of divider and reload follow port writes
`timescale 1ns/1ns
module timer_core_checker
    import timer_pkg::*;
(
    input wire logic clock_in, // clock
    input wire logic rst_in, // reset
    input wire logic [ADDR_W-1:0] addr_in, // index
    input wire logic [DATA_W-1:0] wdata_in, // data
    input wire logic write_in, // write
    input wire logic read_in, // read
    input wire logic [DATA_W-1:0] rdata_out, // rdata
    input wire logic channel_input_signal_in, // in
    input wire logic channel_output_signal_out, // out
    input wire logic channel_output_enable_out, // oe
    input wire logic update_out, // update
    input wire logic capture_out // capture
);
    logic [15:0] div_copy;
    logic [15:0] rel_copy;
    logic [1:0] zero_age;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // copies land on the same edge as the design's registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            div_copy <= 16'h0000;
            rel_copy <= 16'h0000;
        end else if (write_in && addr_in == ADDR_DIVIDER) begin
            div_copy <= wdata_in;
        end else if (write_in && addr_in == ADDR_RELOAD) begin
            rel_copy <= wdata_in;
        end
    end
    // a wrap already in flight may still show for one cycle
    always_ff @(posedge clock_in) begin
        if (rst_in || rel_copy != 16'h0000) begin
            zero_age <= 2'h0;
        end else if (zero_age != 2'h3) begin
            zero_age <= zero_age + 2'h1;
        end
    end
    sequence s_div_rd;
        read_in && addr_in == ADDR_DIVIDER;
    endsequence
    sequence s_rel_rd;
        read_in && addr_in == ADDR_RELOAD;
    endsequence
    chk_rdata_idle: assert property (!read_in |=> rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    chk_reset_quiet: assert property ($fell(rst_in) |-> !update_out && !capture_out
        && !channel_output_enable_out) else $error("outputs active after reset");
    chk_update_single: assert property (update_out |=> !update_out)
        else $error("update pulse too long");
    chk_divider_read: assert property (s_div_rd |=> rdata_out == div_copy)
        else $error("divider read back wrong");
    chk_reload_read: assert property (s_rel_rd |=> rdata_out == rel_copy)
        else $error("reload read back wrong");
    chk_main_off: assert property (write_in && addr_in == ADDR_MAIN && !wdata_in[15]
        |-> ##[1:2] !channel_output_enable_out) else $error("pin driven without main enable");
    chk_enable_off: assert property (write_in && addr_in == ADDR_ENABLE && !wdata_in[0]
        |-> ##[1:2] !channel_output_enable_out) else $error("pin driven while disabled");
    chk_zero_stop: assert property (zero_age >= 2'h2 |-> !update_out)
        else $error("update with zero reload");
    chk_capture_cause: assert property (capture_out |->
        $changed($past(channel_input_signal_in)) || $changed($past(channel_input_signal_in, 2))
        || $changed($past(channel_input_signal_in, 3))) else $error("capture without edge");
endmodule

// ### timer_core_tb.sv
// Purpose: self-checking bench for the timer core
// Assumes: register port tasks, 125 MHz clock
// Notes: reload 3 keeps periods short
`timescale 1ns/1ns
module timer_core_tb
    import timer_pkg::*;
;
    logic clock_in, rst_in, write_in, read_in, cin;
    logic [3:0] addr_in;
    logic [15:0] wdata_in, rdata_out, v;
    logic cout, oe, upd, cap;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int ta, tb, h;
    // enable codes: off, rise, fall, both, reserved
    logic [15:0] cfg [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h000b, 16'h0009};
    int cexp [5] = '{0, 1, 1, 2, 0};
    timer_core i_timer_core (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
        .channel_input_signal_in(cin), .channel_output_signal_out(cout),
        .channel_output_enable_out(oe), .update_out(upd), .capture_out(cap));
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    // hang guard, run needs well under a thousand cycles
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            conclude();
        end
    end
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        write_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        write_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock_in);
        read_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // cycle number of the next update pulse
    task automatic wait_upd(output int t);
        int n;
        n = 0;
        do begin
            @(posedge clock_in);
            #1 n++;
        end while (upd !== 1'b1 && n < 100);
        if (upd !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: no update pulse", $time);
        end
        t = cyc;
    endtask
    task automatic hi(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clock_in);
            #1 c += int'(cout === 1'b1);
        end
    endtask
    // one high pulse on the input, captures counted
    task automatic pulse(output int c);
        c = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clock_in);
            cin <= (i >= 1 && i < 6);
            #1 c += int'(cap === 1'b1);
        end
    endtask
    task automatic oe_is(input logic e);
        repeat (2) @(posedge clock_in);
        #1 check({15'h0000, oe}, {15'h0000, e});
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {rst_in, write_in, read_in, cin, addr_in, wdata_in} = {1'b1, 23'h000000};
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (20) @(posedge clock_in);
        for (int a = 0; a < 4; a++) begin
            rd(a[3:0], v);
            check(v, RESET_ZERO);
        end
        wr(4'hf, 16'hffff);
        rd(4'hf, v);
        check(v, 16'h0000);
        $display("test reset done");
        wr(ADDR_RELOAD, 16'h0003);
        wait_upd(ta);
        wait_upd(tb);
        check(16'(tb - ta), 16'h0004);
        wr(ADDR_DIVIDER, 16'h0001);
        wait_upd(ta);
        check(16'(ta - tb), 16'h0004);
        wait_upd(tb);
        // first period after the update still carries the old tick in flight
        wait_upd(ta);
        check(16'(ta - tb), 16'h0008);
        $display("test timing done");
        wr(ADDR_MAIN, 16'h8000);
        wr(ADDR_MATCH, 16'h0001);
        wr(ADDR_ENABLE, 16'h0001);
        wait_upd(ta);
        hi(16, h);
        check(16'(h), 16'h0004);
        oe_is(1'b1);
        wr(ADDR_ENABLE, 16'h0003);
        wait_upd(ta);
        hi(16, h);
        check(16'(h), 16'h000c);
        wr(ADDR_MAIN, 16'h0000);
        oe_is(1'b0);
        wr(ADDR_MAIN, 16'h8000);
        wr(ADDR_ENABLE, 16'h0000);
        oe_is(1'b0);
        wr(ADDR_MODE, 16'h0008);
        wr(ADDR_ENABLE, 16'h0001);
        wait_upd(ta);
        wr(ADDR_MATCH, 16'h0004);
        @(posedge clock_in);
        hi(3, h);
        check(16'(h), 16'h0000);
        wait_upd(ta);
        hi(16, h);
        check(16'(h), 16'h0010);
        $display("test compare done");
        wr(ADDR_ENABLE, 16'h0000);
        wr(ADDR_MODE, 16'h0001);
        wr(ADDR_RELOAD, 16'h0000);
        wr(ADDR_COUNT, 16'h0002);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_ENABLE, cfg[i]);
            pulse(h);
            check(16'(h), 16'(cexp[i]));
        end
        rd(ADDR_MATCH, v);
        check(v, 16'h0002);
        wr(ADDR_MATCH, 16'h1234);
        rd(ADDR_MATCH, v);
        check(v, 16'h0002);
        wr(ADDR_MODE, 16'h0000);
        wr(ADDR_ENABLE, 16'h0001);
        pulse(h);
        check(16'(h), 16'h0001);
        // both event flags were set earlier; write one clears them
        rd(ADDR_STATUS, v);
        check(v, 16'h0003);
        wr(ADDR_STATUS, 16'h0003);
        rd(ADDR_STATUS, v);
        check(v, 16'h0000);
        $display("test capture done");
        conclude();
    end
endmodule
bind timer_core timer_core_checker i_timer_core_checker (.clock_in(clock_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
    .rdata_out(rdata_out), .channel_input_signal_in(channel_input_signal_in),
    .channel_output_signal_out(channel_output_signal_out),
    .channel_output_enable_out(channel_output_enable_out), .update_out(update_out),
    .capture_out(capture_out));
